// ---- hw/line_ctrl_consts.svh ----
`ifndef LINE_CTRL_CONSTS_SVH
`define LINE_CTRL_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_OWNER_EN      7'h00
`define OFS_OWNER_DIS     7'h04
`define OFS_OWNER_STAT    7'h08
`define OFS_DIR_EN        7'h10
`define OFS_DIR_DIS       7'h14
`define OFS_DIR_STAT      7'h18
`define OFS_FILT_EN       7'h20
`define OFS_FILT_DIS      7'h24
`define OFS_FILT_STAT     7'h28
`define OFS_LVL_SET       7'h30
`define OFS_LVL_CLR       7'h34
`define OFS_LVL_PROG      7'h38
`define OFS_PIN_SAMPLE    7'h3C
`define OFS_IRQ_EN        7'h40
`define OFS_IRQ_DIS       7'h44
`define OFS_IRQ_MASK      7'h48
`define OFS_IRQ_PEND      7'h4C
`define OFS_OD_EN         7'h50
`define OFS_OD_DIS        7'h54
`define OFS_OD_STAT       7'h58

// ==========================================================
// per-instance line maps
`define FIRST_DEFINED     32'h3FFF_FFFF
`define FIRST_MUXED       32'h3FFF_FFFF
`define FIRST_OFF_VALUE   32'h0400_0000
`define SECOND_DEFINED    32'h0FFF_FFFF
`define SECOND_MUXED      32'h0FFF_FFF8
`define SECOND_OFF_VALUE  32'h0000_0000
`define ALL_ZERO          32'h0000_0000
`define ALL_ONE           32'hFFFF_FFFF

`endif

// ---- hw/line_ctrl_pkg.sv ----
package line_ctrl_pkg;
    typedef logic [31:0] line_vec_t;
    typedef logic [6:0]  reg_addr_t;
endpackage

// ---- hw/line_input_cond.sv ----
`timescale 1ns/1ps
`include "line_ctrl_consts.svh"

// ==========================================================
// per-line synchroniser, glitch filter and change detect
module line_input_cond (
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic i_pin,
    input  wire logic i_filter_on,
    output logic      o_level,
    output logic      o_change
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic stable;
    logic level;
    logic next_level;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= i_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // filtered: level moves only after three agreeing samples
    always_comb begin
        next_level = level;
        if (sync_b == sync_c) begin
            next_level = sync_c;
        end
        if (i_filter_on && (sync_c != stable)) begin
            next_level = level;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stable <= 1'b0;
            level  <= 1'b0;
        end else begin
            stable <= sync_c;
            level  <= next_level;
        end
    end

    assign o_level  = level;
    assign o_change = (next_level != level);
endmodule

// ---- hw/parallel_line_controller.sv ----
`timescale 1ns/1ps
`include "line_ctrl_consts.svh"

// ==========================================================
// one controller; instantiate twice with the two maps
module parallel_line_controller #(
    parameter logic [31:0] DEFINED   = `FIRST_DEFINED,
    parameter logic [31:0] MUXED     = `FIRST_MUXED,
    parameter logic [31:0] OFF_VALUE = `FIRST_OFF_VALUE
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic [6:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_irq,
    input  wire logic [31:0] i_pin,
    output logic      [31:0] o_pin,
    output logic      [31:0] o_pin_oen_n,
    input  wire logic [31:0] i_periph_out,
    input  wire logic [31:0] i_periph_oe,
    output logic      [31:0] o_periph_in
);
    line_ctrl_pkg::line_vec_t owner;
    line_ctrl_pkg::line_vec_t dir;
    line_ctrl_pkg::line_vec_t level_prog;
    line_ctrl_pkg::line_vec_t filt;
    line_ctrl_pkg::line_vec_t mask;
    line_ctrl_pkg::line_vec_t pend;
    line_ctrl_pkg::line_vec_t od;
    line_ctrl_pkg::line_vec_t sampled;
    line_ctrl_pkg::line_vec_t change;
    line_ctrl_pkg::line_vec_t wbits;
    line_ctrl_pkg::line_vec_t drv_val;
    line_ctrl_pkg::line_vec_t drv_en;
    line_ctrl_pkg::line_vec_t next_rdata;
    logic                     pend_read;

    // undefined positions can never be written
    assign wbits     = i_wdata & DEFINED;
    assign pend_read = i_rd && (i_addr == `OFS_IRQ_PEND);

    // ======================================================
    // ownership
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            owner <= `ALL_ONE;
        end else if (i_wr && i_addr == `OFS_OWNER_EN) begin
            owner <= owner | (wbits & MUXED);
        end else if (i_wr && i_addr == `OFS_OWNER_DIS) begin
            owner <= owner & ~(wbits & MUXED);
        end
    end

    // ======================================================
    // direction
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dir <= `ALL_ZERO;
        end else if (i_wr && i_addr == `OFS_DIR_EN) begin
            dir <= dir | wbits;
        end else if (i_wr && i_addr == `OFS_DIR_DIS) begin
            dir <= dir & ~wbits;
        end
    end

    // ======================================================
    // programmed level
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            level_prog <= `ALL_ZERO;
        end else if (i_wr && i_addr == `OFS_LVL_SET) begin
            level_prog <= level_prog | wbits;
        end else if (i_wr && i_addr == `OFS_LVL_CLR) begin
            level_prog <= level_prog & ~wbits;
        end
    end

    // ======================================================
    // glitch filter select
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            filt <= `ALL_ZERO;
        end else if (i_wr && i_addr == `OFS_FILT_EN) begin
            filt <= filt | wbits;
        end else if (i_wr && i_addr == `OFS_FILT_DIS) begin
            filt <= filt & ~wbits;
        end
    end

    // ======================================================
    // interrupt mask
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask <= `ALL_ZERO;
        end else if (i_wr && i_addr == `OFS_IRQ_EN) begin
            mask <= mask | wbits;
        end else if (i_wr && i_addr == `OFS_IRQ_DIS) begin
            mask <= mask & ~wbits;
        end
    end

    // ======================================================
    // open drain select
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            od <= `ALL_ZERO;
        end else if (i_wr && i_addr == `OFS_OD_EN) begin
            od <= od | wbits;
        end else if (i_wr && i_addr == `OFS_OD_DIS) begin
            od <= od & ~wbits;
        end
    end

    // ======================================================
    // input conditioning per line
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_line
            if (DEFINED[g]) begin : g_def
                line_input_cond u_cond (
                    .i_ref_clk   (i_ref_clk),
                    .i_resetn    (i_resetn),
                    .i_pin       (i_pin[g]),
                    .i_filter_on (filt[g]),
                    .o_level     (sampled[g]),
                    .o_change    (change[g])
                );
            end else begin : g_undef
                assign sampled[g] = 1'b0;
                assign change[g]  = 1'b0;
            end
        end
    endgenerate

    // ======================================================
    // pending changes; a new change beats the read clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pend <= `ALL_ZERO;
        end else if (pend_read) begin
            pend <= change;
        end else begin
            pend <= pend | change;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_pend_f(pend, change, pend_read) & mask);
        end
    end

    function automatic logic [31:0] next_pend_f(
        input logic [31:0] p,
        input logic [31:0] c,
        input logic        r
    );
        next_pend_f = r ? c : (p | c);
    endfunction

    // ======================================================
    // pin drive and peripheral input
    always_comb begin
        drv_val = (owner & level_prog) | (~owner & i_periph_out);
        drv_en  = (owner & dir) | (~owner & i_periph_oe);
        drv_en  = drv_en & DEFINED;
        // open drain drives only a low level
        drv_en  = drv_en & ~(od & drv_val);
    end

    assign o_pin       = drv_val & ~od;
    assign o_pin_oen_n = ~drv_en;

    // owned lines hand the peripheral its inactive value
    assign o_periph_in = (owner & OFF_VALUE) | (~owner & sampled);

    // ======================================================
    // read data, one cycle after the strobe
    always_comb begin
        next_rdata = `ALL_ZERO;
        unique case (i_addr)
            `OFS_OWNER_STAT: next_rdata = owner;
            `OFS_DIR_STAT:   next_rdata = dir;
            `OFS_FILT_STAT:  next_rdata = filt;
            `OFS_LVL_PROG:   next_rdata = level_prog;
            `OFS_PIN_SAMPLE: next_rdata = sampled;
            `OFS_IRQ_MASK:   next_rdata = mask;
            `OFS_IRQ_PEND:   next_rdata = pend;
            `OFS_OD_STAT:    next_rdata = od;
            default:         next_rdata = `ALL_ZERO;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= `ALL_ZERO;
        end else if (i_rd) begin
            o_rdata <= next_rdata & DEFINED;
        end else begin
            o_rdata <= `ALL_ZERO;
        end
    end
endmodule

// ---- testbench/line_ctrl_checker.sv ----
`timescale 1ns/1ps
`include "line_ctrl_consts.svh"

// ========
// port checks for one controller
module line_ctrl_checker #(
    parameter logic [31:0] DEFINED   = `FIRST_DEFINED,
    parameter logic [31:0] MUXED     = `FIRST_MUXED,
    parameter logic [31:0] OFF_VALUE = `FIRST_OFF_VALUE
) (
    input wire logic        i_ref_clk,
    input wire logic        i_resetn,
    input wire logic [6:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] o_rdata,
    input wire logic        o_irq,
    input wire logic [31:0] o_pin_oen_n,
    input wire logic [31:0] o_periph_in
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    // ========
    // steps
    sequence s_quiet;
        $stable(i_pin)[*8];
    endsequence
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence

    // ========
    // properties
    property p_reset_idle;
        $rose(i_resetn) |-> o_pin_oen_n == '1;
    endproperty
    property p_off_value;
        $rose(i_resetn) |-> o_periph_in == OFF_VALUE;
    endproperty
    property p_rdata_idle;
        !i_rd |=> o_rdata == '0;
    endproperty
    property p_irq_off;
        i_wr && i_addr == `OFS_IRQ_DIS && i_wdata == '1 |=> ##1 !o_irq;
    endproperty
    property p_pend_clear;
        s_quiet ##0 s_rd(`OFS_IRQ_PEND) ##2 s_rd(`OFS_IRQ_PEND)
            |=> o_rdata == '0;
    endproperty
    property p_undef_zero;
        i_rd |=> (o_rdata & ~DEFINED) == '0;
    endproperty
    property p_fixed_owner;
        s_rd(`OFS_OWNER_STAT)
            |=> (o_rdata & DEFINED & ~MUXED) == (DEFINED & ~MUXED);
    endproperty
    property p_pin_sample;
        s_quiet ##0 s_rd(`OFS_PIN_SAMPLE)
            |=> o_rdata == ($past(i_pin) & DEFINED);
    endproperty

    a_reset_idle: assert property (p_reset_idle)
        else $error("pin driven after reset");
    a_off_value: assert property (p_off_value)
        else $error("peripheral input not at off value");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt high with mask cleared");
    a_pend_clear: assert property (p_pend_clear)
        else $error("pending bits kept after read");
    a_undef_zero: assert property (p_undef_zero)
        else $error("undefined bit reads one");
    a_fixed_owner: assert property (p_fixed_owner)
        else $error("dedicated line owner bit low");
    a_pin_sample: assert property (p_pin_sample)
        else $error("pin sample differs from pin");
endmodule

bind parallel_line_controller line_ctrl_checker #(
    .DEFINED(DEFINED), .MUXED(MUXED), .OFF_VALUE(OFF_VALUE)
) u_line_ctrl_checker (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_pin(i_pin),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_pin_oen_n(o_pin_oen_n),
    .o_periph_in(o_periph_in)
);

// ---- testbench/pin_partner.sv ----
`timescale 1ns/1ps

// ========
// external circuit: released lines follow outside level
module pin_partner (
    input  wire logic [31:0] i_drive,
    input  wire logic [31:0] i_drive_oen_n,
    input  wire logic [31:0] i_ext,
    output logic      [31:0] o_wire
);
    always_comb begin
        o_wire = (i_drive & ~i_drive_oen_n) | (i_ext & i_drive_oen_n);
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "line_ctrl_consts.svh"

module tb_top;
    localparam logic [31:0] DEF = `FIRST_DEFINED;
    localparam logic [6:0] BASE [6] = '{`OFS_OWNER_EN, `OFS_DIR_EN,
        `OFS_FILT_EN, `OFS_LVL_SET, `OFS_IRQ_EN, `OFS_OD_EN};
    logic        i_ref_clk, i_resetn, i_wr, i_rd, o_irq;
    logic [6:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, i_pin, o_pin, o_pin_oen_n;
    logic [31:0] o_periph_in, i_periph_out, i_periph_oe, ext;
    logic [31:0] seed, v, w, rd_val;
    logic [31:0] st [6];
    int          n_errors, compares, n;

    parallel_line_controller u_parallel_line_controller (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .i_pin(i_pin), .o_pin(o_pin),
        .o_pin_oen_n(o_pin_oen_n), .i_periph_out(i_periph_out),
        .i_periph_oe(i_periph_oe), .o_periph_in(o_periph_in));
    pin_partner u_pin_partner (.i_drive(o_pin),
        .i_drive_oen_n(o_pin_oen_n), .i_ext(ext), .o_wire(i_pin));

    // ========
    // helpers
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] upd(logic [31:0] s, e, c);
        return (s | e) & ~c & DEF;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [6:0] a, logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [6:0] a);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic flip(logic [31:0] m);
        @(posedge i_ref_clk);
        ext <= ext ^ m;
    endtask

    // ========
    // clock and sequence
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        {n_errors, compares} = 0;
        seed = 32'h7294_21e1;
        {i_resetn, i_wr, i_rd, i_addr, i_wdata} = '0;
        {i_periph_out, i_periph_oe} = '0;
        ext = '1;
        st = '{DEF, 0, 0, 0, 0, 0};
        repeat (16) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 6; k++) begin
                if (r > 0) begin
                    v = xs(seed);
                    seed = xs(v);
                    wr(BASE[k], v);
                    wr(BASE[k] + 7'h04, seed);
                    st[k] = upd(st[k], v, seed);
                end
                rd(BASE[k] + 7'h08);
                chk("status", rd_val, st[k]);
            end
        end
        wr(`OFS_OWNER_EN, '1);
        wr(`OFS_DIR_EN, '1);
        wr(`OFS_OD_DIS, '1);
        seed = xs(seed);
        wr(`OFS_LVL_CLR, '1);
        wr(`OFS_LVL_SET, seed);
        chk("drive", o_pin_oen_n, ~DEF);
        chk("level", o_pin & DEF, seed & DEF);
        wr(`OFS_OD_EN, '1);
        chk("od", o_pin_oen_n, ~DEF | seed);
        wr(`OFS_DIR_DIS, '1);
        chk("input", o_pin_oen_n, '1);
        wr(`OFS_OD_DIS, '1);
        v = xs(seed);
        w = xs(v);
        @(posedge i_ref_clk);
        i_periph_oe <= v;
        i_periph_out <= w;
        wr(`OFS_OWNER_DIS, '1);
        chk("p_oe", o_pin_oen_n & DEF, ~v & DEF);
        chk("p_out", o_pin & ~o_pin_oen_n, w & v & DEF);
        repeat (10) @(posedge i_ref_clk);
        chk("p_in", o_periph_in & DEF, i_pin & DEF);
        rd(`OFS_PIN_SAMPLE);
        chk("sample", rd_val, i_pin & DEF);
        wr(`OFS_OWNER_EN, '1);
        chk("off", o_periph_in, `FIRST_OFF_VALUE);
        wr(`OFS_IRQ_EN, '1);
        repeat (10) @(posedge i_ref_clk);
        rd(`OFS_IRQ_PEND);
        seed = xs(w);
        flip(seed);
        for (n = 0; o_irq !== 1'b1; n++) begin
            if (n == 20) begin
                n_errors++;
                conclude();
            end
            @(posedge i_ref_clk);
            #1;
        end
        rd(`OFS_IRQ_PEND);
        chk("pend", rd_val, seed & DEF);
        rd(`OFS_IRQ_PEND);
        chk("clear", rd_val, '0);
        wr(`OFS_IRQ_DIS, '1);
        flip(seed);
        repeat (10) @(posedge i_ref_clk);
        chk("masked", {31'h0000_0000, o_irq}, '0);
        rd(`OFS_IRQ_PEND);
        chk("pend2", rd_val, seed & DEF);
        // two-cycle pulse passes unfiltered, filter rejects it
        wr(`OFS_FILT_DIS, '1);
        flip(seed);
        @(posedge i_ref_clk);
        flip(seed);
        repeat (10) @(posedge i_ref_clk);
        rd(`OFS_IRQ_PEND);
        chk("pulse", rd_val, seed & DEF);
        wr(`OFS_FILT_EN, '1);
        flip(seed);
        @(posedge i_ref_clk);
        flip(seed);
        repeat (10) @(posedge i_ref_clk);
        rd(`OFS_IRQ_PEND);
        chk("glitch", rd_val, '0);
        rd(`OFS_IRQ_PEND);
        rd(7'h0C);
        chk("unmapped", rd_val, '0);
        conclude();
    end
endmodule
